// ==== hdl/vrsc_map.svh ====
// Purpose: offsets, field positions, reset values and timing in nanoseconds
// Assumes: included by bare name from the package and the controller
// Notes: definitions only
`ifndef VRSC_MAP_SVH
`define VRSC_MAP_SVH

// ==========================================================
// sizes
`define VRSC_MODS 12
`define VRSC_CHANS 16
`define VRSC_LINES 8

// ==========================================================
// event status, status byte
`define VRSC_ESR_PON 7
`define VRSC_ESR_CME 5
`define VRSC_ESR_OPC 0
`define VRSC_ESR_RST 8'h80
`define VRSC_STB_ESB 5
`define VRSC_STB_RQS 6

// ==========================================================
// configuration space selectors and device kind mask
`define VRSC_CFG_ID 1'b0
`define VRSC_CFG_KIND 1'b1
`define VRSC_KIND_MASK 16'hf7ff
// maker code: arbitrary value, names no real maker
`define VRSC_MAKER_ID 16'h5a3c

// ==========================================================
// timing
`define VRSC_CLK_NS 5
`define VRSC_PULSE_NS 3000

`endif

// ==== hdl/vrsc_pkg.sv ====
// Purpose: types shared by the relay scan controller
// Assumes: vrsc_map.svh supplies the sizes
// Notes: none
`include "vrsc_map.svh"

package vrsc_pkg;

  // ==========================================================
  // commands
  typedef enum logic [3:0] {
    OP_CLOSE, OP_OPEN, OP_QCLOSE, OP_QOPEN,
    OP_SCAN, OP_TRG_EN, OP_TRG_Q, OP_IN_SEL,
    OP_IN_POLL, OP_ESR_RD, OP_ESE_WR, OP_SRE_WR,
    OP_STB_RD, OP_TST, OP_ERR, OP_CFG
  } vrsc_op_t;

  typedef enum logic [0:0] {ST_IDLE, ST_MAKE} vrsc_fsm_t;

  // ==========================================================
  // whole controller state
  typedef struct packed {
    vrsc_fsm_t fsm;
    logic strap_done;
    logic [2:0] irq_lvl;
    logic [7:0] laddr;
    logic [15:0] kind;
    logic [3:0] nmods;
    logic [7:0] esr;
    logic [7:0] ese;
    logic [7:0] sre;
    logic [`VRSC_LINES-1:0] trg_en;
    logic [2:0] in_sel;
    logic in_irq;
    logic [`VRSC_LINES-1:0] s1;
    logic [`VRSC_LINES-1:0] s2;
    logic [`VRSC_LINES-1:0] s3;
    logic [`VRSC_LINES-1:0] in_flt;
    logic [`VRSC_MODS-1:0][`VRSC_CHANS-1:0] relay;
    logic [`VRSC_MODS-1:0] scan;
    logic [`VRSC_MODS-1:0] last_vld;
    logic [`VRSC_MODS-1:0][3:0] last_ch;
    logic [3:0] pmod;
    logic [3:0] pch;
    logic [9:0] pcnt;
    logic [`VRSC_MODS-1:0] fail_pend;
    logic rsp_v;
    logic rsp_err;
    logic [15:0] rsp_d;
    logic cpu_irq;
  } vrsc_st_t;

endpackage

// ==== hdl/vrsc_ctrl.sv ====
// Purpose: relay scan controller daughter board logic
// Assumes: one command at a time on the command port, 200 MHz clock
// Notes: channel lists are walked by the commander, one channel a command
//
// Overview of operation
// - interrupt level from switch, levels 1 to 7
// - logical address from switch, 0 to 255
// - fixed read-only maker and device-kind registers
// - kind is inverted three-digit model, masked f7ff
// - any trigger lines driven, or all undriven
// - one trigger input, polled or interrupting
// - one to twelve modules, named by position
// - self-test answers 0 pass, 1 fail
// - power-on bit 128 set until first read
// - event status read returns then clears
// - trigger 1 low 3 us after close
// - trigger enable query answers 1 or 0
// - closed query: 1 closed, 0 open
// - open query: 1 open, 0 closed
// - scan mode opens previous before closing new
// - status bit 5 summary, bit 6 request
`timescale 1ns/1ps
`include "vrsc_map.svh"

module vrsc_ctrl #(
  parameter int PULSE_NS = `VRSC_PULSE_NS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_irq_level_sw,
  input wire logic [7:0] i_laddr_sw,
  input wire logic [11:0] i_model_bcd,
  input wire logic [3:0] i_module_count,
  input wire logic [`VRSC_MODS-1:0] i_selftest_fail,
  input wire logic [7:0] i_bus_laddr,
  output logic o_addr_hit,
  output logic [2:0] o_irq_level,
  output logic o_irq_req,
  output logic o_srq,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic [3:0] i_cmd_op,
  input wire logic [3:0] i_cmd_mod,
  input wire logic [3:0] i_cmd_chan,
  input wire logic [7:0] i_cmd_arg,
  output logic o_rsp_valid,
  output logic o_rsp_err,
  output logic [15:0] o_rsp_data,
  input wire logic [`VRSC_LINES-1:0] i_ttl_trg_i,
  output logic [`VRSC_LINES-1:0] o_ttl_trg_o,
  output logic [`VRSC_LINES-1:0] o_ttl_trg_oe,
  output logic o_cpu_trg_irq,
  output logic [`VRSC_MODS*`VRSC_CHANS-1:0] o_relay_close
);

  // ==========================================================
  // constants
  localparam int PULSE_CYC = (PULSE_NS + `VRSC_CLK_NS - 1) / `VRSC_CLK_NS;

  vrsc_pkg::vrsc_st_t st_q;
  vrsc_pkg::vrsc_st_t st_d;
  vrsc_pkg::vrsc_op_t op;
  logic [3:0] mi;
  logic bad_mod;
  logic close_evt;
  logic [7:0] ev_set;
  logic esb;
  logic rqs;
  logic [7:0] stb;
  logic [9:0] model_bin;
  logic [`VRSC_MODS-1:0] present;
  logic [`VRSC_MODS-1:0] fail_now;
  logic err_found;
  logic [3:0] err_idx;

  // ==========================================================
  // status byte summary
  always_comb begin
    esb = |(st_q.esr & st_q.ese);
    rqs = esb & st_q.sre[`VRSC_STB_ESB];
    stb = 8'h00;
    stb[`VRSC_STB_ESB] = esb;
    stb[`VRSC_STB_RQS] = rqs;
  end

  // three bcd digits to binary, widened for the kind register
  assign model_bin = 10'(i_model_bcd[11:8]) * 10'd100
                   + 10'(i_model_bcd[7:4]) * 10'd10
                   + 10'(i_model_bcd[3:0]);
  assign present = `VRSC_MODS'((13'h0001 << st_q.nmods) - 13'h0001);
  assign fail_now = i_selftest_fail & present;
  assign op = vrsc_pkg::vrsc_op_t'(i_cmd_op);
  assign mi = i_cmd_mod - 4'h1;
  assign bad_mod = (i_cmd_mod == 4'h0) || (i_cmd_mod > st_q.nmods);

  // lowest pending self-test failure
  always_comb begin
    err_found = 1'b0;
    err_idx = 4'h0;
    for (int k = `VRSC_MODS - 1; k >= 0; k--) begin
      if (st_q.fail_pend[k]) begin
        err_found = 1'b1;
        err_idx = 4'(k);
      end
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    st_d = st_q;
    st_d.rsp_v = 1'b0;
    st_d.rsp_err = 1'b0;
    st_d.cpu_irq = 1'b0;
    close_evt = 1'b0;
    ev_set = 8'h00;

    // trigger pins: only s2 and s3 judge a change
    st_d.s1 = i_ttl_trg_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < `VRSC_LINES; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.in_flt[i] = st_q.s2[i];
      end
    end
    // asserted-low line: falling edge is the event
    if (st_q.in_irq && st_q.in_flt[st_q.in_sel]
        && !st_d.in_flt[st_q.in_sel]) begin
      st_d.cpu_irq = 1'b1;
    end

    // straps caught once, just after reset release
    if (!st_q.strap_done) begin
      st_d.strap_done = 1'b1;
      st_d.irq_lvl = i_irq_level_sw;
      st_d.laddr = i_laddr_sw;
      st_d.kind = ~{6'h00, model_bin} & `VRSC_KIND_MASK;
      if (i_module_count == 4'h0) begin
        st_d.nmods = 4'h1;
      end else if (i_module_count > 4'(`VRSC_MODS)) begin
        st_d.nmods = 4'(`VRSC_MODS);
      end else begin
        st_d.nmods = i_module_count;
      end
    end

    if (st_q.pcnt != 10'h000) begin
      st_d.pcnt = st_q.pcnt - 10'h001;
    end

    unique case (st_q.fsm)
      vrsc_pkg::ST_IDLE: begin
        if (i_cmd_valid && st_q.strap_done) begin
          st_d.rsp_v = 1'b1;
          st_d.rsp_d = 16'h0000;
          unique case (op)
            vrsc_pkg::OP_CLOSE, vrsc_pkg::OP_OPEN, vrsc_pkg::OP_QCLOSE,
            vrsc_pkg::OP_QOPEN, vrsc_pkg::OP_SCAN: begin
              if (bad_mod) begin
                st_d.rsp_err = 1'b1;
                ev_set[`VRSC_ESR_CME] = 1'b1;
              end else if (op == vrsc_pkg::OP_CLOSE) begin
                if (st_q.scan[mi] && st_q.last_vld[mi]
                    && st_q.last_ch[mi] != i_cmd_chan) begin
                  // break first, make on the next edge
                  st_d.relay[mi][st_q.last_ch[mi]] = 1'b0;
                  st_d.pmod = mi;
                  st_d.pch = i_cmd_chan;
                  st_d.rsp_v = 1'b0;
                  st_d.fsm = vrsc_pkg::ST_MAKE;
                end else begin
                  st_d.relay[mi][i_cmd_chan] = 1'b1;
                  st_d.last_ch[mi] = i_cmd_chan;
                  st_d.last_vld[mi] = 1'b1;
                  close_evt = 1'b1;
                end
              end else if (op == vrsc_pkg::OP_OPEN) begin
                st_d.relay[mi][i_cmd_chan] = 1'b0;
                if (st_q.last_ch[mi] == i_cmd_chan) begin
                  st_d.last_vld[mi] = 1'b0;
                end
              end else if (op == vrsc_pkg::OP_QCLOSE) begin
                st_d.rsp_d[0] = st_q.relay[mi][i_cmd_chan];
              end else if (op == vrsc_pkg::OP_QOPEN) begin
                st_d.rsp_d[0] = ~st_q.relay[mi][i_cmd_chan];
              end else begin
                st_d.scan[mi] = i_cmd_arg[0];
                st_d.last_vld[mi] = 1'b0;
              end
            end
            vrsc_pkg::OP_TRG_EN: st_d.trg_en = i_cmd_arg;
            vrsc_pkg::OP_TRG_Q: begin
              st_d.rsp_d[0] = st_q.trg_en[i_cmd_arg[2:0]];
            end
            vrsc_pkg::OP_IN_SEL: begin
              st_d.in_sel = i_cmd_arg[2:0];
              st_d.in_irq = i_cmd_arg[3];
            end
            vrsc_pkg::OP_IN_POLL: st_d.rsp_d[0] = st_q.in_flt[st_q.in_sel];
            vrsc_pkg::OP_ESR_RD: begin
              st_d.rsp_d[7:0] = st_q.esr;
              st_d.esr = 8'h00;
            end
            vrsc_pkg::OP_ESE_WR: st_d.ese = i_cmd_arg;
            vrsc_pkg::OP_SRE_WR: st_d.sre = i_cmd_arg;
            vrsc_pkg::OP_STB_RD: st_d.rsp_d[7:0] = stb;
            vrsc_pkg::OP_TST: begin
              st_d.fail_pend = fail_now;
              st_d.rsp_d[0] = |fail_now;
            end
            vrsc_pkg::OP_ERR: begin
              // module name number of the next failure, 0 when none
              if (err_found) begin
                st_d.rsp_d[3:0] = err_idx + 4'h1;
                st_d.fail_pend[err_idx] = 1'b0;
              end
            end
            vrsc_pkg::OP_CFG: begin
              st_d.rsp_d = (i_cmd_arg[0] == `VRSC_CFG_KIND) ?
                           st_q.kind : `VRSC_MAKER_ID;
            end
          endcase
          if (op == vrsc_pkg::OP_CFG && i_cmd_arg[1]) begin
            ev_set[`VRSC_ESR_OPC] = 1'b0;
          end
          if (op == vrsc_pkg::OP_STB_RD && i_cmd_arg[7]) begin
            // arg bit 7 on a status read marks operation complete
            ev_set[`VRSC_ESR_OPC] = 1'b1;
          end
        end
      end
      vrsc_pkg::ST_MAKE: begin
        st_d.relay[st_q.pmod][st_q.pch] = 1'b1;
        st_d.last_ch[st_q.pmod] = st_q.pch;
        st_d.last_vld[st_q.pmod] = 1'b1;
        close_evt = 1'b1;
        st_d.rsp_v = 1'b1;
        st_d.rsp_d = 16'h0000;
        st_d.fsm = vrsc_pkg::ST_IDLE;
      end
    endcase

    // new events win over a same-cycle read clear
    st_d.esr = st_d.esr | ev_set;
    // a close restarts the pulse, so back-to-back closes stretch it
    if (close_evt) begin
      st_d.pcnt = 10'(PULSE_CYC);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
      st_q.esr <= `VRSC_ESR_RST;
      st_q.nmods <= 4'h1;
      st_q.s1 <= '1;
      st_q.s2 <= '1;
      st_q.s3 <= '1;
      st_q.in_flt <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  assign o_cmd_ready = (st_q.fsm == vrsc_pkg::ST_IDLE) && st_q.strap_done;
  assign o_rsp_valid = st_q.rsp_v;
  assign o_rsp_err = st_q.rsp_err;
  assign o_rsp_data = st_q.rsp_d;
  assign o_addr_hit = st_q.strap_done && (i_bus_laddr == st_q.laddr);
  assign o_irq_level = st_q.irq_lvl;
  // level 0 on the switch means the interrupter is off
  assign o_irq_req = rqs && (st_q.irq_lvl != 3'h0);
  assign o_srq = rqs;
  // open-collector lines: only ever pull low, else float
  assign o_ttl_trg_o = '0;
  assign o_ttl_trg_oe = st_q.trg_en & {`VRSC_LINES{st_q.pcnt != 10'h000}};
  assign o_cpu_trg_irq = st_q.cpu_irq;
  assign o_relay_close = st_q.relay;

  // ==========================================================
  // checks
  pon_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(st_q.strap_done) |-> st_q.esr[`VRSC_ESR_PON])
    else $error("power-on bit not set after reset");

  esr_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_cmd_ready && i_cmd_valid && op == vrsc_pkg::OP_ESR_RD
    |=> o_rsp_data[7:0] == $past(st_q.esr) && st_q.esr == 8'h00)
    else $error("event status not returned then cleared");

  stb_sum_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st_q.esr & st_q.ese) == 8'h00 |-> !o_srq && !o_irq_req)
    else $error("service request without an enabled event");

  scan_break_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_cmd_ready && i_cmd_valid && op == vrsc_pkg::OP_CLOSE && !bad_mod
    && st_q.scan[mi] && st_q.last_vld[mi] && st_q.last_ch[mi] != i_cmd_chan
    |=> !st_q.relay[st_q.pmod][$past(st_q.last_ch[mi])]
    && !st_q.relay[st_q.pmod][st_q.pch] && !o_rsp_valid
    ##1 st_q.relay[st_q.pmod][st_q.pch] && o_rsp_valid)
    else $error("scan close did not break before make");

  trg_float_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st_q.trg_en == '0 |-> o_ttl_trg_oe == '0)
    else $error("trigger driven while all disabled");

  trg_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    close_evt && st_q.trg_en[1]
    |=> (o_ttl_trg_oe[1] && !o_ttl_trg_o[1])[*8])
    else $error("trigger 1 not pulled low after close");

  pulse_len_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !close_evt && st_q.pcnt != 10'h000
    |=> st_q.pcnt == $past(st_q.pcnt) - 10'h001)
    else $error("trigger pulse count did not step down");

  pulse_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    close_evt |=> st_q.pcnt == 10'(PULSE_CYC))
    else $error("trigger pulse not restarted by a close");

  bad_mod_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_cmd_ready && i_cmd_valid && i_cmd_op < 4'h5 && bad_mod
    |=> o_rsp_valid && o_rsp_err && st_q.esr[`VRSC_ESR_CME])
    else $error("bad module number not refused");

  irq_lvl_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_irq_req |-> o_irq_level != 3'h0 && o_srq)
    else $error("interrupt raised with no level");

  tst_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_cmd_ready && i_cmd_valid && op == vrsc_pkg::OP_TST
    |=> o_rsp_valid && o_rsp_data == {15'h0000, |$past(fail_now)})
    else $error("self-test answer wrong");

  qopen_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_cmd_ready && i_cmd_valid && op == vrsc_pkg::OP_QOPEN && !bad_mod
    |=> o_rsp_data[0] != $past(st_q.relay[mi][i_cmd_chan]))
    else $error("open query does not invert close state");

  kind_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st_q.strap_done |-> (st_q.kind & ~`VRSC_KIND_MASK) == 16'h0000)
    else $error("device kind not masked");

endmodule

// ==== bench/vrsc_far.sv ====
// Purpose: far side of the trigger backplane lines
// Assumes: every party only pulls a line low, a pull-up holds it high
// Notes: the bench pulls lines through i_ext_low
`timescale 1ns/1ps
`include "vrsc_map.svh"

module vrsc_far (
  input wire logic [`VRSC_LINES-1:0] i_dut_oe,
  input wire logic [`VRSC_LINES-1:0] i_ext_low,
  output logic [`VRSC_LINES-1:0] o_lines
);
  // ==========================================================
  // wired-and: a released line reads high, never the last value
  assign o_lines = ~(i_dut_oe | i_ext_low);
endmodule

// ==== bench/vxi_relay_scan_controller_tb_top.sv ====
// Purpose: self-checking bench for the relay scan controller
// Assumes: short trigger pulse parameter, six modules fitted
// Notes: commands are driven at the falling edge
`timescale 1ns/1ps
`include "vrsc_map.svh"

module vxi_relay_scan_controller_tb_top;
  localparam int PNS = 50;
  localparam int PCYC = PNS / `VRSC_CLK_NS;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [2:0] irq_sw = 3'h1;
  logic [7:0] laddr_sw = 8'h00, bus_laddr = 8'h00, c_arg = 8'h00;
  logic [11:0] bcd = 12'h000;
  logic [11:0] fail = 12'h000;
  logic [3:0] c_mod = 4'h0, c_chan = 4'h0;
  logic c_valid = 1'b0, scan_on = 1'b0;
  vrsc_pkg::vrsc_op_t c_op = vrsc_pkg::OP_CLOSE;
  logic [7:0] ext_low = 8'h00, lines, mask;
  logic o_addr_hit, o_irq_req, o_srq, o_cmd_ready, o_rsp_valid, o_rsp_err;
  logic o_cpu_trg_irq;
  logic [2:0] o_irq_level;
  logic [15:0] o_rsp_data, rsp;
  logic [7:0] o_ttl_trg_o, o_ttl_trg_oe;
  logic [191:0] o_relay_close, model;
  logic rerr;
  int miscompares = 0, checks = 0, n, sa, sb;
  time t_drop = 0;

  always #2.5 i_sys_clk = ~i_sys_clk;

  vrsc_ctrl #(.PULSE_NS(PNS)) DUT (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_irq_level_sw(irq_sw),
    .i_laddr_sw(laddr_sw), .i_model_bcd(bcd), .i_module_count(4'h6),
    .i_selftest_fail(fail), .i_bus_laddr(bus_laddr),
    .o_addr_hit(o_addr_hit), .o_irq_level(o_irq_level),
    .o_irq_req(o_irq_req), .o_srq(o_srq), .i_cmd_valid(c_valid),
    .o_cmd_ready(o_cmd_ready), .i_cmd_op(c_op), .i_cmd_mod(c_mod),
    .i_cmd_chan(c_chan), .i_cmd_arg(c_arg), .o_rsp_valid(o_rsp_valid),
    .o_rsp_err(o_rsp_err), .o_rsp_data(o_rsp_data), .i_ttl_trg_i(lines),
    .o_ttl_trg_o(o_ttl_trg_o), .o_ttl_trg_oe(o_ttl_trg_oe),
    .o_cpu_trg_irq(o_cpu_trg_irq), .o_relay_close(o_relay_close));

  vrsc_far FAR (.i_dut_oe(o_ttl_trg_oe), .i_ext_low(ext_low),
    .o_lines(lines));

  // ==========================================================
  // reporting
  task automatic bad(input logic [15:0] g, input logic [15:0] e);
    $display("BAD %0t got %h expected %h", $time, g, e);
    miscompares++;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      bad(g, e);
    end
  endtask

  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // expectations
  function automatic logic [15:0] kind_of(input logic [11:0] b);
    int d;
    d = b[11:8] * 100 + b[7:4] * 10 + b[3:0];
    return ~16'(d) & `VRSC_KIND_MASK;
  endfunction

  // ==========================================================
  // one command, called and left at a falling edge
  task automatic cmd(input vrsc_pkg::vrsc_op_t op, input logic [3:0] m,
                     input logic [3:0] ch, input logic [7:0] a);
    int k;
    // valid was lowered in this very step: let an edge pass first
    if (t_drop == $time) begin
      @(negedge i_sys_clk);
    end
    c_op = op;
    c_mod = m;
    c_chan = ch;
    c_arg = a;
    c_valid = 1'b1;
    k = 0;
    while (o_cmd_ready !== 1'b1 && k < 50) begin
      @(negedge i_sys_clk);
      k++;
    end
    @(negedge i_sys_clk);
    c_valid = 1'b0;
    t_drop = $time;
    k = 0;
    while (o_rsp_valid !== 1'b1 && k < 50) begin
      @(negedge i_sys_clk);
      k++;
    end
    if (k >= 50) begin
      bad(16'h0, 16'h1);
      close_out();
    end else begin
      rsp = o_rsp_data;
      rerr = o_rsp_err;
    end
  endtask

  // count cycles that the pins show exactly the given pull-down set
  task automatic pulse_len(input logic [7:0] want);
    n = 0;
    repeat (PCYC + 4) begin
      if (o_ttl_trg_oe === want) begin
        n++;
      end
      @(negedge i_sys_clk);
    end
  endtask

  // break-before-make: both scan channels never closed together
  always @(negedge i_sys_clk) begin
    if (scan_on && o_relay_close[sa] === 1'b1
        && o_relay_close[sb] === 1'b1) begin
      bad(16'h3, 16'h1);
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h9282));
    irq_sw = 3'($urandom_range(7, 1));
    laddr_sw = 8'($urandom);
    bcd = {4'($urandom_range(9)), 4'($urandom_range(9)),
           4'($urandom_range(9))};
    model = '0;
    repeat (10) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    chk(16'(o_irq_level), 16'(irq_sw));
    bus_laddr = laddr_sw;
    #1 chk(16'(o_addr_hit), 16'h1);
    bus_laddr = ~laddr_sw;
    #1 chk(16'(o_addr_hit), 16'h0);
    @(negedge i_sys_clk);
    cmd(vrsc_pkg::OP_ESR_RD, 4'h0, 4'h0, 8'h00);
    chk(rsp, 16'h0080);
    cmd(vrsc_pkg::OP_ESR_RD, 4'h0, 4'h0, 8'h00);
    chk(rsp, 16'h0000);
    cmd(vrsc_pkg::OP_CFG, 4'h0, 4'h0, 8'h00);
    chk(rsp, `VRSC_MAKER_ID);
    cmd(vrsc_pkg::OP_CFG, 4'h0, 4'h0, 8'h01);
    chk(rsp, kind_of(bcd));
    // trigger outputs, line 1 always among them
    mask = 8'($urandom) | 8'h02;
    cmd(vrsc_pkg::OP_TRG_EN, 4'h0, 4'h0, mask);
    for (int l = 0; l < 8; l++) begin
      cmd(vrsc_pkg::OP_TRG_Q, 4'h0, 4'h0, 8'(l));
      chk(rsp, 16'(mask[l]));
    end
    cmd(vrsc_pkg::OP_CLOSE, 4'h1, 4'h3, 8'h00);
    model[3] = 1'b1;
    pulse_len(mask);
    chk(16'(n), 16'(PCYC));
    chk(16'(o_ttl_trg_o), 16'h0);
    cmd(vrsc_pkg::OP_TRG_EN, 4'h0, 4'h0, 8'h00);
    cmd(vrsc_pkg::OP_CLOSE, 4'h2, 4'h0, 8'h00);
    model[16] = 1'b1;
    pulse_len(8'h00);
    chk(16'(n), 16'(PCYC + 4));
    // random open and close over modules 1 to 5
    repeat (30) begin
      c_mod = 4'($urandom_range(5, 1));
      c_chan = 4'($urandom);
      n = (int'(c_mod) - 1) * 16 + int'(c_chan);
      if ($urandom_range(1)) begin
        cmd(vrsc_pkg::OP_CLOSE, c_mod, c_chan, 8'h00);
        model[n] = 1'b1;
      end else begin
        cmd(vrsc_pkg::OP_OPEN, c_mod, c_chan, 8'h00);
        model[n] = 1'b0;
      end
      cmd(vrsc_pkg::OP_QCLOSE, c_mod, c_chan, 8'h00);
      chk(rsp, 16'(model[n]));
      cmd(vrsc_pkg::OP_QOPEN, c_mod, c_chan, 8'h00);
      chk(rsp, 16'(!model[n]));
      chk(o_relay_close[191:176], 16'h0);
      chk(o_relay_close[79:0] === model[79:0], 1'b1);
    end
    // scan mode on module 6
    sa = 80 + 2;
    sb = 80 + 9;
    cmd(vrsc_pkg::OP_SCAN, 4'h6, 4'h0, 8'h01);
    cmd(vrsc_pkg::OP_CLOSE, 4'h6, 4'h2, 8'h00);
    scan_on = 1'b1;
    cmd(vrsc_pkg::OP_CLOSE, 4'h6, 4'h9, 8'h00);
    chk(16'(o_relay_close[sa]), 16'h0);
    chk(16'(o_relay_close[sb]), 16'h1);
    scan_on = 1'b0;
    // bad module numbers feed the status byte
    cmd(vrsc_pkg::OP_ESE_WR, 4'h0, 4'h0, 8'h20);
    cmd(vrsc_pkg::OP_SRE_WR, 4'h0, 4'h0, 8'h20);
    cmd(vrsc_pkg::OP_CLOSE, 4'h7, 4'h0, 8'h00);
    chk(16'(rerr), 16'h1);
    cmd(vrsc_pkg::OP_OPEN, 4'h0, 4'h0, 8'h00);
    chk(16'(rerr), 16'h1);
    chk(16'({o_srq, o_irq_req}), 16'h3);
    cmd(vrsc_pkg::OP_STB_RD, 4'h0, 4'h0, 8'h00);
    chk(rsp, 16'h0060);
    cmd(vrsc_pkg::OP_ESR_RD, 4'h0, 4'h0, 8'h00);
    chk(rsp, 16'h0020);
    cmd(vrsc_pkg::OP_STB_RD, 4'h0, 4'h0, 8'h80);
    chk(rsp, 16'h0000);
    chk(16'({o_srq, o_irq_req}), 16'h0);
    cmd(vrsc_pkg::OP_ESR_RD, 4'h0, 4'h0, 8'h00);
    chk(rsp, 16'h0001);
    // self-test: modules 2 and 5 fail, 12 is not fitted
    fail = 12'h812;
    cmd(vrsc_pkg::OP_TST, 4'h0, 4'h0, 8'h00);
    chk(rsp, 16'h0001);
    cmd(vrsc_pkg::OP_ERR, 4'h0, 4'h0, 8'h00);
    chk(rsp, 16'h0002);
    cmd(vrsc_pkg::OP_ERR, 4'h0, 4'h0, 8'h00);
    chk(rsp, 16'h0005);
    cmd(vrsc_pkg::OP_ERR, 4'h0, 4'h0, 8'h00);
    chk(rsp, 16'h0000);
    fail = 12'h000;
    cmd(vrsc_pkg::OP_TST, 4'h0, 4'h0, 8'h00);
    chk(rsp, 16'h0000);
    // trigger input on line 5, interrupting
    cmd(vrsc_pkg::OP_IN_SEL, 4'h0, 4'h0, 8'h0d);
    ext_low[5] = 1'b1;
    n = 0;
    repeat (8) begin
      @(negedge i_sys_clk);
      n += int'(o_cpu_trg_irq === 1'b1);
    end
    chk(16'(n), 16'h1);
    cmd(vrsc_pkg::OP_IN_POLL, 4'h0, 4'h0, 8'h00);
    chk(rsp, 16'h0000);
    ext_low[5] = 1'b0;
    repeat (6) @(negedge i_sys_clk);
    cmd(vrsc_pkg::OP_IN_POLL, 4'h0, 4'h0, 8'h00);
    chk(rsp, 16'h0001);
    close_out();
  end
endmodule
